// File: bench/switch_partition_control_props.sv
`timescale 1ns/10ps
`include "partition_defines.svh"
module switch_partition_control_chk import partition_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [63:0] port_partition_select,
   input wire logic [31:0] port_mode,
   input wire logic ctl_wr_en,
   input wire logic [3:0] ctl_wr_id,
   input wire logic [1:0] ctl_wr_state,
   input wire logic tlp_valid,
   input wire logic tlp_to_root,
   input wire logic route_valid,
   input wire logic [1:0] route_action,
   input wire logic [15:0] upstream_present,
   input wire logic [63:0] upstream_port_number,
   input wire logic [31:0] partition_state,
   input wire logic [15:0] link_down_hot_reset_enable,
   input wire logic [31:0] port_eff_mode,
   input wire logic [15:0] port_reset
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // control writes pass the store, then the output register
   sequence ctl_write_s;
      ctl_wr_en ##2 1'b1;
   endsequence
   sequence reset_entry_s;
      ctl_wr_en && ctl_wr_state == `STATE_FUND_RESET ##2 1'b1;
   endsequence
   state_latency_a: assert property (
      ctl_write_s |-> partition_state[2*$past(ctl_wr_id, 2) +: 2] == $past(ctl_wr_state, 2))
      else $error("partition state did not follow the write");
   hrst_reinit_a: assert property (
      reset_entry_s |-> !link_down_hot_reset_enable[$past(ctl_wr_id, 2)])
      else $error("hot reset enable kept on reset entry");
   route_pulse_a: assert property (route_valid == $past(tlp_valid))
      else $error("route answer not one cycle after query");
   drop_cause_a: assert property (
      route_valid && route_action == route_drop |-> $past(tlp_to_root))
      else $error("drop without a root-bound tlp");
   free_port_a: assert property (
      !port_mode[1] |=> port_eff_mode[1:0] == $past(port_mode[1:0]))
      else $error("free port mode altered");
   disabled_forces_a: assert property (
      $past(port_mode[1]) && $past(port_partition_select[3:0]) == 4'h7
      && partition_state[15:14] == `STATE_DISABLED |-> port_eff_mode[1:0] == `MODE_DISABLED)
      else $error("port of disabled partition not disabled");
   reset_follows_a: assert property (
      $past(port_mode[5]) && $past(port_partition_select[11:8]) == 4'h5
      |-> port_reset[2] == (partition_state[11:10] == `STATE_FUND_RESET))
      else $error("port reset does not track partition reset");
   upstream_flag_a: assert property (
      $past(port_mode[31:30]) == `MODE_UPSTREAM
      |-> upstream_present[$past(port_partition_select[63:60])])
      else $error("upstream present missing");
   upstream_id_a: assert property (
      $past(port_mode[31:30]) == `MODE_UPSTREAM
      |-> upstream_port_number[4*$past(port_partition_select[63:60]) +: 4] == 4'hF)
      else $error("upstream port number wrong");
endmodule : switch_partition_control_chk
bind switch_partition_control switch_partition_control_chk i_chk (.clk, .rst_n,
   .port_partition_select, .port_mode, .ctl_wr_en, .ctl_wr_id, .ctl_wr_state, .tlp_valid,
   .tlp_to_root, .route_valid, .route_action, .upstream_present, .upstream_port_number,
   .partition_state, .link_down_hot_reset_enable, .port_eff_mode, .port_reset);

// File: bench/switch_partition_control_tb_top.sv
`timescale 1ns/10ps
`include "partition_defines.svh"
module switch_partition_control_tb_top import partition_pkg::*;;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [63:0] port_partition_select = 64'h0;
   logic [31:0] port_mode = 32'h0;
   logic ctl_wr_en = 1'b0;
   logic [3:0] ctl_wr_id = 4'h0;
   logic [1:0] ctl_wr_state = 2'h0;
   logic ctl_wr_hrst = 1'b0;
   logic tlp_valid, tlp_is_completion, tlp_is_cfg_to_us, tlp_to_root, tlp_dst_valid, route_valid;
   logic [3:0] tlp_src_port, tlp_dst_port;
   logic [1:0] route_action;
   logic [15:0] upstream_present, link_down_hot_reset_enable, port_reset, port_aspm_independent;
   logic [63:0] upstream_port_number;
   logic [31:0] partition_state, port_eff_mode;
   logic [2:0] seen;
   int n_errors = 0;
   int checked = 0;
   switch_partition_control i_switch_partition_control (.clk, .rst_n, .port_partition_select,
      .port_mode, .ctl_wr_en, .ctl_wr_id, .ctl_wr_state, .ctl_wr_hrst, .tlp_valid, .tlp_src_port,
      .tlp_is_completion, .tlp_is_cfg_to_us, .tlp_to_root, .tlp_dst_valid, .tlp_dst_port,
      .route_valid, .route_action, .upstream_present, .upstream_port_number, .partition_state,
      .link_down_hot_reset_enable, .port_eff_mode, .port_reset, .port_aspm_independent);
   tlp_agent i_tlp_agent (.clk, .tlp_valid, .tlp_src_port, .tlp_is_completion, .tlp_is_cfg_to_us,
      .tlp_to_root, .tlp_dst_valid, .tlp_dst_port, .route_valid, .route_action);
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask : chk
   // status lags by two registers, so let three edges pass before looking
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask : settle
   task automatic set_port(input int p, input logic [3:0] sel, input logic [1:0] mode);
      @(posedge clk);
      port_partition_select[4*p +: 4] <= sel;
      port_mode[2*p +: 2] <= mode;
   endtask : set_port
   task automatic wr_ctl(input logic [3:0] id, input logic [1:0] st, input logic hr);
      @(posedge clk);
      ctl_wr_en <= 1'b1;
      ctl_wr_id <= id;
      ctl_wr_state <= st;
      ctl_wr_hrst <= hr;
      @(posedge clk);
      ctl_wr_en <= 1'b0;
      settle();
   endtask : wr_ctl
   task automatic route(input logic [3:0] src, input logic [3:0] kind, input logic [3:0] dst,
         input route_type exp);
      i_tlp_agent.query(src, kind, dst, seen);
      chk(seen, {1'b1, exp});
   endtask : route
   task automatic conclude();
      if (n_errors == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      settle();
      chk(partition_state, 64'h0);
      // only legal layouts: switch, downstream-only, upstream-only
      set_port(2, 4'h5, `MODE_UPSTREAM);
      set_port(3, 4'h5, `MODE_DOWNSTREAM);
      set_port(4, 4'h5, `MODE_UNATTACHED);
      set_port(0, 4'h7, `MODE_DOWNSTREAM);
      set_port(8, 4'h7, `MODE_DOWNSTREAM);
      set_port(15, 4'h9, `MODE_UPSTREAM);
      settle();
      chk(upstream_present, 64'h220);
      chk(upstream_port_number[23:20], 64'h2);
      chk(upstream_port_number[39:36], 64'hF);
      chk(port_eff_mode[5:4], `MODE_DISABLED);
      chk(port_eff_mode[9:8], `MODE_UNATTACHED);
      chk(port_aspm_independent, 64'h8101);
      wr_ctl(4'h5, `STATE_ACTIVE, 1'b0);
      wr_ctl(4'h7, `STATE_ACTIVE, 1'b0);
      wr_ctl(4'h9, `STATE_ACTIVE, 1'b0);
      chk(partition_state[19:18], `STATE_ACTIVE);
      chk(port_eff_mode[5:4], `MODE_UPSTREAM);
      route(4'h3, 4'h0, 4'h0, route_forward);
      route(4'h4, 4'h1, 4'h3, route_unsupported);
      route(4'h0, 4'h1, 4'h8, route_forward);
      route(4'h0, 4'h1, 4'h3, route_unsupported);
      route(4'h0, 4'h2, 4'h0, route_drop);
      route(4'hF, 4'h4, 4'h0, route_forward);
      route(4'hF, 4'h8, 4'h0, route_unsupported);
      route(4'hF, 4'h0, 4'h0, route_unsupported);
      wr_ctl(4'h5, `STATE_FUND_RESET, 1'b1);
      chk(port_reset, 64'hC);
      chk(link_down_hot_reset_enable[5], 64'h0);
      route(4'h3, 4'h0, 4'h0, route_unsupported);
      wr_ctl(4'h5, `STATE_ACTIVE, 1'b1);
      chk(link_down_hot_reset_enable[5], 64'h1);
      chk(port_reset, 64'h0);
      wr_ctl(4'h7, `STATE_DISABLED, 1'b0);
      chk(port_eff_mode[1:0], `MODE_DISABLED);
      conclude();
   end
   // the sequence above needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      conclude();
   end
endmodule : switch_partition_control_tb_top

// File: bench/tlp_agent.sv
`timescale 1ns/10ps
// far side: offers one tlp per query and collects the routing verdict
module tlp_agent (
   input wire logic clk,
   output logic tlp_valid,
   output logic [3:0] tlp_src_port,
   output logic tlp_is_completion,
   output logic tlp_is_cfg_to_us,
   output logic tlp_to_root,
   output logic tlp_dst_valid,
   output logic [3:0] tlp_dst_port,
   input wire logic route_valid,
   input wire logic [1:0] route_action
);
   initial begin
      {tlp_valid, tlp_src_port, tlp_dst_port} = 9'h0;
      {tlp_is_completion, tlp_is_cfg_to_us, tlp_to_root, tlp_dst_valid} = 4'h0;
   end
   // kind is {completion, cfg to upstream, toward root, dst valid}; ports inverted once idle
   task automatic query(input logic [3:0] src, input logic [3:0] kind, input logic [3:0] dst,
         output logic [2:0] seen);
      @(posedge clk);
      tlp_valid <= 1'b1;
      tlp_src_port <= src;
      {tlp_is_completion, tlp_is_cfg_to_us, tlp_to_root, tlp_dst_valid} <= kind;
      tlp_dst_port <= dst;
      @(posedge clk);
      tlp_valid <= 1'b0;
      {tlp_src_port, tlp_dst_port} <= ~{src, dst};
      #1 seen = {route_valid, route_action};
   endtask : query
endmodule : tlp_agent

// File: logic/partition_defines.svh
`ifndef PARTITION_DEFINES_SVH
`define PARTITION_DEFINES_SVH
`define NUM_PARTITIONS 16
`define NUM_PORTS 16
`define PART_ID_W 4
`define PORT_ID_W 4
`define MODE_W 2
`define STATE_W 2
`define MODE_DISABLED 2'h0
`define MODE_UNATTACHED 2'h1
`define MODE_UPSTREAM 2'h2
`define MODE_DOWNSTREAM 2'h3
`define STATE_DISABLED 2'h0
`define STATE_FUND_RESET 2'h1
`define STATE_ACTIVE 2'h2
`define CTL_RESET_STATE 2'h0
`define CTL_RESET_HRST 1'h0
`endif

// File: logic/partition_pkg.sv
package partition_pkg;
   typedef enum logic [1:0] {
      ptype_empty,
      ptype_switch,
      ptype_no_upstream
   } layout_type;
   typedef enum logic [1:0] {
      route_forward,
      route_unsupported,
      route_drop
   } route_type;
endpackage : partition_pkg

// File: logic/partition_state_store.sv
`timescale 1ns/10ps
`include "partition_defines.svh"
// per-partition control store; software writes, fundamental reset entry re-initialises
module partition_state_store
   import partition_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [3:0] wr_id,
   input wire logic [1:0] wr_state,
   input wire logic wr_hrst,
   output logic [31:0] state_flat,
   output logic [15:0] hrst_flat
);
   genvar g;
   generate
      for (g = 0; g < `NUM_PARTITIONS; g++) begin : g_part
         logic [1:0] state_reg;
         logic hrst_reg;
         wire hit = wr_en && (wr_id == 4'(g));
         // a write entering fundamental reset also restores the option bits
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               state_reg <= `CTL_RESET_STATE;
               hrst_reg <= `CTL_RESET_HRST;
            end else if (hit) begin
               state_reg <= wr_state;
               hrst_reg <= (wr_state == `STATE_FUND_RESET) ? `CTL_RESET_HRST : wr_hrst;
            end
         end
         assign state_flat[2*g +: 2] = state_reg;
         assign hrst_flat[g] = hrst_reg;
      end
   endgenerate
endmodule : partition_state_store

// File: logic/switch_partition_control.sv
`timescale 1ns/10ps
`include "partition_defines.svh"
// Summary of operation
// R01: sixteen partitions, numbered 0 through 15.
// R02: port attaches only with matching partition select and upstream or downstream mode.
// R03: disabled or unattached ports belong nowhere and ignore partition state.
// R04: software uses only empty, one-upstream, or downstream-only layouts.
// R05: upstream-present set whenever an upstream-mode port is attached.
// R06: while upstream-present, status reports the upstream port number.
// R07: a partition without ports has no effect.
// R08: one upstream plus downstream ports acts as a normal switch.
// R09: upstream-only partition: all but upstream config requests are unsupported.
// R10: upstream-only partition: upstream ASPM is independent of downstream ports.
// R11: partition without upstream still forwards peer-to-peer TLPs.
// R12: partition without upstream: TLPs not to its downstream ports unsupported.
// R13: partition without upstream: switch TLPs toward root dropped silently.
// R14: partition without upstream: downstream ASPM ignores upstream state.
// R15: each partition is disabled, fundamental reset or active per its state field.
// R16: software requests only permitted state transitions.
// R17: disabled partition forces its attached ports into disabled mode.
// R18: fundamental reset holds partition logic and ports in reset.
// R19: entering fundamental reset restores partition registers to initial values.
// R20: after initialization, registers stay writable from other masters.
// R21: partition reset lasts while state field selects fundamental reset.
// R22: system meets base reset timing before leaving reset for active.
// R23: active partitions switch normally; all listed moves are accepted.
module switch_partition_control
   import partition_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   // per-port control, flattened: port p at [p*W +: W]
   input wire logic [63:0] port_partition_select,
   input wire logic [31:0] port_mode,
   // partition control write strobe
   input wire logic ctl_wr_en,
   input wire logic [3:0] ctl_wr_id,
   input wire logic [1:0] ctl_wr_state,
   input wire logic ctl_wr_hrst,
   // per-TLP routing query from the port datapath
   input wire logic tlp_valid,
   input wire logic [3:0] tlp_src_port,
   input wire logic tlp_is_completion,
   input wire logic tlp_is_cfg_to_us,
   input wire logic tlp_to_root,
   input wire logic tlp_dst_valid,
   input wire logic [3:0] tlp_dst_port,
   output logic route_valid,
   output logic [1:0] route_action,
   // partition status
   output logic [15:0] upstream_present,
   output logic [63:0] upstream_port_number,
   output logic [31:0] partition_state,
   output logic [15:0] link_down_hot_reset_enable,
   // per-port effective results
   output logic [31:0] port_eff_mode,
   output logic [15:0] port_reset,
   output logic [15:0] port_aspm_independent
);
   logic [31:0] state_flat;
   logic [15:0] hrst_flat;

   // control registers are writable at any time, by any master path [R20] [R23]
   partition_state_store u_store (
      .clk(clk),
      .rst_n(rst_n),
      .wr_en(ctl_wr_en),
      .wr_id(ctl_wr_id),
      .wr_state(ctl_wr_state),
      .wr_hrst(ctl_wr_hrst),
      .state_flat(state_flat),
      .hrst_flat(hrst_flat)
   );

   // a port counts as attached only in an operational mode [R02] [R03]
   function automatic logic is_attached(input logic [1:0] m);
      return (m == `MODE_UPSTREAM) || (m == `MODE_DOWNSTREAM);
   endfunction : is_attached

   function automatic logic [1:0] part_state(input logic [31:0] f, input logic [3:0] id);
      return f[2*id +: 2];
   endfunction : part_state

   logic [15:0] attached;
   logic [15:0] is_us;
   logic [15:0] is_ds;
   logic [3:0] sel [16];
   logic [31:0] eff_mode_w;
   logic [15:0] port_rst_w;

   genvar p;
   generate
      for (p = 0; p < `NUM_PORTS; p++) begin : g_port
         assign sel[p] = port_partition_select[4*p +: 4];
         assign attached[p] = is_attached(port_mode[2*p +: 2]); // [R02] [R03]
         assign is_us[p] = port_mode[2*p +: 2] == `MODE_UPSTREAM;
         assign is_ds[p] = port_mode[2*p +: 2] == `MODE_DOWNSTREAM;
         // disabled partition overrides mode; unattached ports keep their own [R17] [R03]
         assign eff_mode_w[2*p +: 2] = (attached[p] &&
            part_state(state_flat, sel[p]) == `STATE_DISABLED) ? `MODE_DISABLED
            : port_mode[2*p +: 2];
         // reset held for as long as the field selects it [R18] [R21]
         assign port_rst_w[p] = attached[p] &&
            part_state(state_flat, sel[p]) == `STATE_FUND_RESET;
      end
   endgenerate

   // per-partition membership summary [R01]
   logic [15:0] has_us;
   logic [15:0] has_ds;
   logic [3:0] us_num [16];
   // one process owns all summary bits, so each vector has a single driver;
   // the highest-numbered upstream port wins if software breaks the layout rules
   always_comb begin
      has_us = 16'h0000;
      has_ds = 16'h0000;
      for (int j = 0; j < `NUM_PARTITIONS; j++) begin
         us_num[j] = 4'h0;
      end
      for (int i = 0; i < `NUM_PORTS; i++) begin
         if (is_us[i]) begin
            has_us[sel[i]] = 1'b1; // [R05]
            us_num[sel[i]] = 4'(i); // [R06]
         end
         if (is_ds[i]) begin
            has_ds[sel[i]] = 1'b1;
         end
      end
   end

   // aspm independence: upstream-only, or downstream-only partitions
   logic [15:0] aspm_w;
   generate
      for (p = 0; p < `NUM_PORTS; p++) begin : g_aspm
         assign aspm_w[p] = (is_us[p] && !has_ds[sel[p]]) // [R10]
            || (is_ds[p] && !has_us[sel[p]]); // [R14]
      end
   endgenerate

   // routing decision for one received TLP
   wire [3:0] src_part = sel[tlp_src_port];
   wire src_att = attached[tlp_src_port];
   wire src_active = part_state(state_flat, src_part) == `STATE_ACTIVE;
   wire src_has_us = has_us[src_part];
   wire src_has_ds = has_ds[src_part];
   wire dst_ok = tlp_dst_valid && is_ds[tlp_dst_port] && sel[tlp_dst_port] == src_part;
   logic [1:0] route_w;
   always_comb begin
      if (!src_att || !src_active) begin
         route_w = route_unsupported; // no partition, or not switching [R07] [R03]
      end else if (src_has_us && !src_has_ds) begin
         route_w = tlp_is_cfg_to_us && !tlp_is_completion ? route_forward
            : route_unsupported; // [R09]
      end else if (!src_has_us) begin
         if (tlp_to_root) begin
            route_w = route_drop; // [R13]
         end else if (dst_ok) begin
            route_w = route_forward; // peer-to-peer continues [R11]
         end else begin
            route_w = route_unsupported; // [R12]
         end
      end else begin
         route_w = route_forward; // normal switch [R08] [R23]
      end
   end

   // every output is registered; layouts outside R04 and transitions outside R16 are
   // not checked, the datapath behaviour is then whatever falls out
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         route_valid <= 1'b0;
         route_action <= 2'h0;
         upstream_present <= 16'h0000;
         upstream_port_number <= 64'h0;
         partition_state <= 32'h0;
         link_down_hot_reset_enable <= 16'h0000;
         port_eff_mode <= 32'h0;
         port_reset <= 16'h0000;
         port_aspm_independent <= 16'h0000;
      end else begin
         route_valid <= tlp_valid;
         route_action <= route_w;
         upstream_present <= has_us; // [R05]
         for (int k = 0; k < `NUM_PARTITIONS; k++) begin
            upstream_port_number[4*k +: 4] <= has_us[k] ? us_num[k] : 4'h0; // [R06]
         end
         partition_state <= state_flat; // [R15]
         link_down_hot_reset_enable <= hrst_flat; // [R19]
         port_eff_mode <= eff_mode_w; // [R17]
         port_reset <= port_rst_w; // [R18]
         port_aspm_independent <= aspm_w;
      end
   end
endmodule : switch_partition_control
